/* logic/module_reset_sequencer_consts.svh */
`ifndef MODULE_RESET_SEQUENCER_CONSTS_SVH
`define MODULE_RESET_SEQUENCER_CONSTS_SVH

// ****************************************
// sizes
// ****************************************
`define MRS_ID_W         4                 // swappable module index width
`define MRS_DEPTH        16                // settings entries, one per module
`define MRS_DUR_W        8                 // reset length field, holds length minus one
`define MRS_CNT_W        3                 // width of the settle counter

// ****************************************
// timing and power-on values
// ****************************************
`define MRS_FETCH_DELAY  3'h6              // cycles from reset release to settings fetch
`define MRS_POR_HIGH     1'b1              // polarity chosen when the core was generated
`define MRS_DUR_ZERO     8'h00             // counter expiry value
`define MRS_CNT_ZERO     3'h0              // settle counter start value
`define MRS_CNT_ONE      3'h1              // settle counter step
`define MRS_ID_ZERO      4'h0              // neutral module index at reset

`endif

/* logic/module_reset_sequencer_pkg.sv */
package module_reset_sequencer_pkg;
`include "module_reset_sequencer_consts.svh"

  // ****************************************
  // per-module stored settings
  // ****************************************
  typedef struct packed {
    logic                  reset_en;     // reset output used for this module
    logic                  active_high;  // asserted level of the reset output
    logic                  sw_bringup;   // software handshake before reset
    logic [`MRS_DUR_W-1:0] dur_m1;       // reset length minus one (1..256 cycles)
  } module_settings_t;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_SETTLE  = 3'b000,                 // waiting after reset release
    ST_IDLE    = 3'b001,                 // active or shutdown, nothing running
    ST_LOADING = 3'b010,                 // isolated, module being loaded
    ST_FETCH   = 3'b011,                 // settings read issued
    ST_DECIDE  = 3'b100,                 // settings available
    ST_SW_WAIT = 3'b101,                 // waiting for continue command
    ST_RELEASE = 3'b110,                 // isolation dropped this cycle
    ST_RESET   = 3'b111                  // reset held asserted
  } seq_state_t;

endpackage : module_reset_sequencer_pkg

/* logic/module_settings_mem.sv */
`timescale 1ns/1ps
`include "module_reset_sequencer_consts.svh"

// ****************************************
// settings store, registered read data
// ****************************************
module module_settings_mem
  import module_reset_sequencer_pkg::*;
(
  input  wire logic                 clk_sys_in,  // controller clock
  input  wire logic                 we_in,       // write strobe
  input  wire logic [`MRS_ID_W-1:0] waddr_in,    // write index
  input  module_settings_t          wdata_in,    // write data
  input  wire logic                 re_in,       // read strobe
  input  wire logic [`MRS_ID_W-1:0] raddr_in,    // read index
  output module_settings_t          rdata_out    // read data, one cycle after re_in
);

  module_settings_t mem_q [`MRS_DEPTH];          // storage, no reset so a restart keeps it
  module_settings_t rdata_q;                     // read register

  // write port and registered read
  always_ff @(posedge clk_sys_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
    if (re_in) begin
      rdata_q <= mem_q[raddr_in];
    end
  end

  assign rdata_out = rdata_q;

endmodule : module_settings_mem

/* logic/module_reset_sequencer.sv */
// Function
// - per-module reset enable, polarity and length
// - reset after load when enabled
// - reset after restart if full, enabled, not skipped
// - shutdown lets control interfaces drive reset
// - software handshake completes before reset
// - otherwise deasserted; restart reloads the generated deasserted level
// - reset asserts cycle after isolation release
// - skip option keeps reset off after restart
// - power-on level from generated polarity
// - settings fetched six cycles after release
// - generated polarity used until fetch completes
// - isolation held from shutdown end to bringup
`timescale 1ns/1ps
`include "module_reset_sequencer_consts.svh"

module module_reset_sequencer
  import module_reset_sequencer_pkg::*;
(
  input  wire logic                 clk_sys_in,             // controller clock, 50 MHz
  input  wire logic                 rst_in,                 // async restart, active high
  input  wire logic                 socket_full_in,         // a module is resident
  input  wire logic [`MRS_ID_W-1:0] resident_id_in,         // resident module index
  input  wire logic                 skip_bringup_in,        // skip bringup after restart
  input  wire logic                 shutdown_in,            // manager in shutdown state
  input  wire logic                 load_start_in,          // shutdown steps done, pulse
  input  wire logic                 load_done_in,           // module loaded, pulse
  input  wire logic [`MRS_ID_W-1:0] load_id_in,             // index of loaded module
  input  wire logic                 proceed_in,             // continue command, pulse
  input  wire logic                 ctl_a_we_in,            // register interface write
  input  wire logic                 ctl_a_reset_in,         // its reset value
  input  wire logic                 ctl_b_we_in,            // stream interface write
  input  wire logic                 ctl_b_reset_in,         // its reset value
  input  wire logic                 cfg_we_in,              // settings write strobe
  input  wire logic [`MRS_ID_W-1:0] cfg_id_in,              // settings index
  input  module_settings_t          cfg_data_in,            // settings value
  output logic                      module_reset_out,       // reset to the module
  output logic                      module_isolate_out,     // isolation control
  output logic                      sw_bringup_request_out, // software bringup request
  output logic                      busy_out                // sequence in progress
);

  // ****************************************
  // state
  // ****************************************
  seq_state_t              state_q, state_d;      // sequencer state
  logic [`MRS_CNT_W-1:0]   settle_q, settle_d;    // cycles since release
  logic [`MRS_DUR_W-1:0]   dur_q, dur_d;          // reset cycles left
  logic [`MRS_ID_W-1:0]    id_q, id_d;            // module being handled
  logic                    restart_q, restart_d;  // sequence came from a restart
  logic                    pol_q, pol_d;          // asserted level in use
  logic                    direct_q, direct_d;    // shutdown direct reset value
  logic                    iso_q, iso_d;          // isolation register
  logic                    lvl_q, lvl_d;          // reset pin level
  logic                    req_q, req_d;          // bringup request register
  logic                    act_d;                 // reset asserted next cycle
  logic                    rd_en;                 // settings read strobe
  module_settings_t        set_rd;                // settings read data

  // ****************************************
  // settings memory
  // ****************************************
  module_settings_mem u_mem (
    .clk_sys_in (clk_sys_in),
    .we_in      (cfg_we_in),
    .waddr_in   (cfg_id_in),
    .wdata_in   (cfg_data_in),
    .re_in      (rd_en),
    .raddr_in   (id_q),
    .rdata_out  (set_rd)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    state_d   = state_q;
    settle_d  = settle_q;
    dur_d     = dur_q;
    id_d      = id_q;
    restart_d = restart_q;
    pol_d     = pol_q;
    direct_d  = direct_q;
    iso_d     = iso_q;
    rd_en     = 1'b0;
    case (state_q)
      // hold generated polarity until the fetch lands
      ST_SETTLE: begin
        id_d      = resident_id_in;
        restart_d = 1'b1;
        settle_d  = settle_q + `MRS_CNT_ONE;
        if (settle_q == `MRS_FETCH_DELAY - `MRS_CNT_ONE - `MRS_CNT_ONE) begin
          state_d = ST_FETCH;
        end
      end
      ST_IDLE: begin
        if (shutdown_in) begin
          // either control interface steers the pin; isolation keeps its value
          if (ctl_a_we_in) begin
            direct_d = ctl_a_reset_in;
          end else if (ctl_b_we_in) begin
            direct_d = ctl_b_reset_in;
          end
        end else begin
          direct_d = 1'b0;
          iso_d    = ~socket_full_in;
          if (load_start_in) begin
            iso_d   = 1'b1;
            state_d = ST_LOADING;
          end
        end
      end
      ST_LOADING: begin
        if (load_done_in) begin
          id_d      = load_id_in;
          restart_d = 1'b0;
          state_d   = ST_FETCH;
        end
      end
      ST_FETCH: begin
        rd_en   = 1'b1;
        state_d = ST_DECIDE;
      end
      ST_DECIDE: begin
        pol_d = set_rd.active_high;
        dur_d = set_rd.dur_m1;
        if (restart_q) begin
          // restart: only a full, enabled, non-skipped socket is reset
          if (!socket_full_in || !set_rd.reset_en || skip_bringup_in) begin
            state_d = ST_IDLE;
          end else if (set_rd.sw_bringup) begin
            state_d = ST_SW_WAIT;
          end else begin
            state_d = ST_RESET;
          end
        end else if (set_rd.sw_bringup) begin
          state_d = ST_SW_WAIT;
        end else begin
          state_d = ST_RELEASE;
        end
      end
      ST_SW_WAIT: begin
        // no time limit on software
        if (proceed_in) begin
          state_d = restart_q ? ST_RESET : ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        iso_d = 1'b0;
        if (set_rd.reset_en) begin
          state_d = ST_RESET;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_RESET: begin
        if (dur_q == `MRS_DUR_ZERO) begin
          state_d = ST_IDLE;
        end else begin
          dur_d = dur_q - {{(`MRS_DUR_W-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // asserted only in the three cases, deasserted level otherwise;
    // the pin follows the registered state, so it asserts one cycle after
    // isolation drops and an edge-sensitive module sees a deasserted cycle first
    act_d = (state_q == ST_RESET) ||
            ((state_q == ST_IDLE) && shutdown_in && direct_q);
    lvl_d = act_d ? pol_d : ~pol_d;
    req_d = (state_d == ST_SW_WAIT);
  end

  // ****************************************
  // registers
  // ****************************************
  // a restart reloads the generated deasserted level; with unedited
  // settings this equals the level already on the pin
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q   <= ST_SETTLE;
      settle_q  <= `MRS_CNT_ZERO;
      dur_q     <= `MRS_DUR_ZERO;
      id_q      <= `MRS_ID_ZERO;
      restart_q <= 1'b1;
      pol_q     <= `MRS_POR_HIGH;
      direct_q  <= 1'b0;
      iso_q     <= 1'b0;
      lvl_q     <= ~`MRS_POR_HIGH;
      req_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      settle_q  <= settle_d;
      dur_q     <= dur_d;
      id_q      <= id_d;
      restart_q <= restart_d;
      pol_q     <= pol_d;
      direct_q  <= direct_d;
      iso_q     <= iso_d;
      lvl_q     <= lvl_d;
      req_q     <= req_d;
    end
  end

  assign module_reset_out       = lvl_q;
  assign module_isolate_out     = iso_q;
  assign sw_bringup_request_out = req_q;
  assign busy_out               = (state_q != ST_IDLE);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  property p_release_then_reset;
    $fell(module_isolate_out) && (state_q == ST_RESET) |->
      ($past(state_q) == ST_RELEASE) && (module_reset_out != pol_q)
      ##1 module_reset_out == pol_q;
  endproperty
  a_release_then_reset: assert property (p_release_then_reset)
    else $error("reset did not follow isolation release");

  property p_len;
    $rose(state_q == ST_RESET) && (dur_q == 8'h02) |->
      ##1 (module_reset_out == pol_q)[*3] ##1 (module_reset_out != pol_q);
  endproperty
  a_len: assert property (p_len)
    else $error("reset length wrong");

  property p_off_level;
    !$past(state_q == ST_RESET) &&
      !$past(state_q == ST_IDLE && shutdown_in && direct_q) |->
      module_reset_out == ~pol_q;
  endproperty
  a_off_level: assert property (p_off_level)
    else $error("reset asserted outside allowed cases");

  property p_sw_first;
    (state_q == ST_SW_WAIT) |-> module_reset_out == ~pol_q && sw_bringup_request_out;
  endproperty
  a_sw_first: assert property (p_sw_first)
    else $error("reset before software bringup done");

  property p_proceed;
    (state_q == ST_SW_WAIT) && proceed_in |=> !sw_bringup_request_out;
  endproperty
  a_proceed: assert property (p_proceed)
    else $error("bringup request not dropped on continue");

  property p_iso_held;
    (state_q == ST_LOADING) || (state_q == ST_SW_WAIT && !restart_q) |-> module_isolate_out;
  endproperty
  a_iso_held: assert property (p_iso_held)
    else $error("isolation dropped early");

  property p_skip;
    (state_q == ST_DECIDE) && restart_q && skip_bringup_in |=> state_q == ST_IDLE;
  endproperty
  a_skip: assert property (p_skip)
    else $error("restart bringup not skipped");

  property p_fetch_time;
    $fell(rst_in) |-> ##5 state_q == ST_FETCH ##1 state_q == ST_DECIDE;
  endproperty
  a_fetch_time: assert property (@(posedge clk_sys_in) p_fetch_time)
    else $error("settings fetch not at expected cycle");

  property p_direct;
    (state_q == ST_IDLE) && shutdown_in && ctl_a_we_in && shutdown_in ##1 shutdown_in
      && state_q == ST_IDLE |-> ##1 module_reset_out == ($past(ctl_a_reset_in, 2) ~^ pol_q);
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct reset control not reflected");

  property p_restart_reset;
    (state_q == ST_DECIDE) && restart_q && socket_full_in && set_rd.reset_en &&
      !skip_bringup_in && !set_rd.sw_bringup |=> state_q == ST_RESET;
  endproperty
  a_restart_reset: assert property (p_restart_reset)
    else $error("restart reset not started");

  c_load_reset:   cover property ($rose(state_q == ST_RESET) && !restart_q);
  c_restart_rst:  cover property ($rose(state_q == ST_RESET) && restart_q);
  c_sw_wait:      cover property (state_q == ST_SW_WAIT ##1 proceed_in);
  c_direct_reset: cover property (shutdown_in && direct_q);

endmodule : module_reset_sequencer

/* verif/swappable_module_model.sv */
`timescale 1ns/1ps

// ****************************************
// swappable module seen through its reset pin
// ****************************************
module swappable_module_model (
  input  wire logic clk_sys_in,     // controller clock
  input  wire logic reset_in,       // module reset pin
  input  wire logic isolate_in,     // isolation, high hides the pin
  input  wire logic active_high_in, // asserted level of this module
  output int        pulse_cnt_out,  // completed reset pulses
  output int        pulse_len_out,  // length of the last pulse
  output logic      edge_ok_out     // every assertion had an idle cycle first
);
  logic raw;            // pin at asserted level
  logic raw_q = 1'b0;   // raw one sample ago
  logic iso_q = 1'b0;   // isolation one sample ago
  int   run   = 0;      // cycles of the running pulse

  assign raw = (reset_in === active_high_in);

  initial begin
    pulse_cnt_out = 0;
    pulse_len_out = 0;
    edge_ok_out   = 1'b1;
  end

  // behind isolation an edge-sensitive module misses the reset edge
  always @(posedge clk_sys_in) begin
    if (raw && !raw_q && iso_q) begin
      edge_ok_out <= 1'b0;
    end
    if (raw && !isolate_in) begin
      run <= run + 1;
    end else if (run > 0) begin
      pulse_cnt_out <= pulse_cnt_out + 1;
      pulse_len_out <= run;
      run           <= 0;
    end
    raw_q <= raw;
    iso_q <= isolate_in;
  end
endmodule : swappable_module_model

/* verif/tb_top.sv */
`timescale 1ns/1ps

// ****************************************
// reset sequencer bench
// ****************************************
module tb_top
  import module_reset_sequencer_pkg::*;
;
  logic clk_sys_in = 1'b0;                         // 50 MHz clock
  logic rst_in = 1'b1;                             // restart, held at start
  logic full = 1'b1, skip = 1'b0, shut = 1'b0;     // manager levels
  logic ld_start = 1'b0, ld_done = 1'b0;           // load pulses
  logic proceed = 1'b0, cfg_we = 1'b0;             // continue, settings strobe
  logic a_we = 1'b0, a_v = 1'b0, b_we = 1'b0, b_v = 1'b0; // direct writes
  logic [3:0] rid = 4'h0, lid = 4'h0, cid = 4'h0;  // module indices
  module_settings_t cdat = '0;                     // settings value
  module_settings_t s;                             // scenario settings
  logic rst_pin, iso, req, busy;                   // design outputs
  logic pol = 1'b1;                                // asserted level in place
  logic edge_ok;                                   // partner verdict
  int pcnt, plen, k, c0;                           // partner counts, scratch
  int n_mismatch = 0, n_checks = 0, seed = 51902, tick = 0;

  module_reset_sequencer u_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .socket_full_in(full),
    .resident_id_in(rid), .skip_bringup_in(skip), .shutdown_in(shut),
    .load_start_in(ld_start), .load_done_in(ld_done), .load_id_in(lid),
    .proceed_in(proceed), .ctl_a_we_in(a_we), .ctl_a_reset_in(a_v),
    .ctl_b_we_in(b_we), .ctl_b_reset_in(b_v), .cfg_we_in(cfg_we),
    .cfg_id_in(cid), .cfg_data_in(cdat), .module_reset_out(rst_pin),
    .module_isolate_out(iso), .sw_bringup_request_out(req), .busy_out(busy));

  swappable_module_model u_mod (
    .clk_sys_in(clk_sys_in), .reset_in(rst_pin), .isolate_in(iso),
    .active_high_in(pol), .pulse_cnt_out(pcnt), .pulse_len_out(plen),
    .edge_ok_out(edge_ok));

  // ****************************************
  // clock and hang guard
  // ****************************************
  always #10 clk_sys_in = ~clk_sys_in;

  // the longest run is under a thousand cycles, so this only trips on a hang
  always @(posedge clk_sys_in) begin
    tick <= tick + 1;
    if (tick == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic end_sim();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : cyc

  task automatic pulse(ref logic p);
    p = 1'b1;
    cyc(1);
    p = 1'b0;
  endtask : pulse

  task automatic cfg_wr(input logic [3:0] id, input module_settings_t d);
    cfg_we = 1'b1;
    cid = id;
    cdat = d;
    cyc(1);
    cfg_we = 1'b0;
  endtask : cfg_wr

  // direct reset writes, pin shows them one edge after they are taken
  task automatic ctl(input logic aw, av, bw, bv);
    {a_we, a_v, b_we, b_v} = {aw, av, bw, bv};
    cyc(1);
    {a_we, b_we} = 2'b00;
    cyc(1);
  endtask : ctl

  // restart with module 5 resident, settings written while held
  task automatic restart(input module_settings_t r, input logic sk, input int n);
    rst_in = 1'b1;
    // the pin drops to the generated level at once, so the model follows now
    pol = r.active_high;
    skip = sk;
    rid = 4'h5;
    cfg_wr(4'h5, r);
    cyc(n);
    chk(rst_pin === 1'b0, "pin not at idle level in restart");
    c0 = pcnt;
    rst_in = 1'b0;
    if (r.sw_bringup && r.reset_en && !sk) begin
      k = 0;
      while (req !== 1'b1 && k < 30) begin
        cyc(1);
        k++;
      end
      chk(req === 1'b1 && iso === 1'b0, "no request after restart");
      cyc(4);
      chk(pcnt === c0 && rst_pin === ~pol, "reset before continue");
      pulse(proceed);
    end
    cyc(r.dur_m1 + 30);
    chk(pcnt === c0 + int'(r.reset_en && !sk), "restart pulse count");
    if (r.reset_en && !sk) begin
      chk(plen === r.dur_m1 + 1, "restart pulse length");
    end
  endtask : restart

  // one full load of module id with settings d
  task automatic do_load(input logic [3:0] id, input module_settings_t d);
    cfg_wr(id, d);
    c0 = pcnt;
    pulse(ld_start);
    cyc(1);
    chk(iso === 1'b1 && busy === 1'b1, "no isolation on load");
    lid = id;
    pulse(ld_done);
    // pin takes the new polarity at the settings fetch, two edges on
    cyc(2);
    pol = d.active_high;
    if (d.sw_bringup) begin
      cyc(3);
      chk(req === 1'b1 && iso === 1'b1 && pcnt === c0, "bringup wait");
      pulse(proceed);
    end
    k = 0;
    while (iso !== 1'b0 && k < 20) begin
      cyc(1);
      k++;
    end
    chk(iso === 1'b0 && rst_pin === ~pol, "pin as isolation drops");
    cyc(1);
    chk(rst_pin === (d.reset_en ? pol : ~pol), "pin after isolation");
    k = 0;
    while (busy !== 1'b0 && k < 300) begin
      cyc(1);
      k++;
    end
    cyc(2);
    chk(rst_pin === ~pol && pcnt === c0 + int'(d.reset_en), "load pulse count");
    if (d.reset_en) begin
      chk(plen === d.dur_m1 + 1, "load pulse length");
    end
  endtask : do_load

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    s = '{reset_en: 1'b1, active_high: 1'b1, sw_bringup: 1'b0, dur_m1: 8'h02};
    restart(s, 1'b0, 20);
    // random settings, first one with the longest length
    for (int i = 0; i < 12; i++) begin
      s = 11'($random(seed));
      s.dur_m1 = (i == 0) ? 8'hFF : (s.dur_m1 & 8'h0F);
      do_load(4'(i), s);
    end
    shut = 1'b1;
    cyc(1);
    pulse(ld_start);
    cyc(1);
    chk(busy === 1'b0 && iso === 1'b0, "load taken in shutdown");
    ctl(1'b1, 1'b1, 1'b0, 1'b0);
    chk(rst_pin === pol, "first interface write");
    ctl(1'b1, 1'b0, 1'b1, 1'b1);
    chk(rst_pin === ~pol, "first interface must win");
    ctl(1'b0, 1'b0, 1'b1, 1'b1);
    chk(rst_pin === pol, "second interface write");
    shut = 1'b0;
    cyc(3);
    chk(rst_pin === ~pol, "reset left on after shutdown");
    s = '{reset_en: 1'b1, active_high: 1'b1, sw_bringup: 1'b0, dur_m1: 8'h03};
    restart(s, 1'b1, 3);
    s.sw_bringup = 1'b1;
    restart(s, 1'b0, 3);
    // edited polarity: generated level holds until the fetch lands
    s = '{reset_en: 1'b0, active_high: 1'b0, sw_bringup: 1'b0, dur_m1: 8'h00};
    rst_in = 1'b1;
    cfg_wr(4'h5, s);
    cyc(2);
    rst_in = 1'b0;
    cyc(2);
    chk(rst_pin === 1'b0, "generated level not kept");
    cyc(12);
    chk(rst_pin === 1'b1 && busy === 1'b0, "stored level not taken");
    chk(edge_ok === 1'b1, "assertion began behind isolation");
    end_sim();
  end
endmodule : tb_top
